// *** verilog/rtcap_pkg.sv ***
// Constants, register layout and carrier types of the alert pin block.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register port.
package rtcap_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_FLAGS = 3'h0;
  localparam logic [2:0] IDX_CTRL  = 3'h6;
  localparam logic [2:0] IDX_STAT  = 3'h7;

  // Flags register layout, most significant bit first.
  typedef struct packed {
    logic watchdog_expired_flag;
    logic af;
    logic pf;
    logic osc_stop_flag;
    logic backup_supply_fail_flag;
    logic cal;
    logic wen;
    logic rlatch;
  } rtcap_flags_t;

  // Alert control register layout, most significant bit first.
  typedef struct packed {
    logic watchdog_alert_enable;
    logic alarm_alert_enable;
    logic powerfail_alert_enable;
    logic square_wave_enable;
    logic act_high;
    logic pulse_sel;
    logic rate_hi;
    logic rate_lo;
  } rtcap_ctrl_t;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h08;

  // Status register bits.
  localparam int STAT_BACKUP = 0;
  localparam int STAT_ALERT  = 1;
  localparam int STAT_PULSE  = 2;

  // Timing: the tick runs at twice the highest square-wave rate.
  localparam int CLK_HZ   = 250_000_000;
  localparam int TICK_HZ  = 65536;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int PULSE_MS = 200;
  localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;

  // Tick counter bit that toggles at each selectable rate.
  localparam int BIT_1HZ     = 15;
  localparam int BIT_512HZ   = 6;
  localparam int BIT_4096HZ  = 3;
  localparam int BIT_32768HZ = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin source select, Gray coded along OFF, ALERT, SQW, CAL.
  typedef enum logic [1:0] {
    PIN_OFF   = 2'h0,
    PIN_ALERT = 2'h1,
    PIN_SQW   = 2'h3,
    PIN_CAL   = 2'h2
  } rtcap_pin_t;

endpackage

// *** verilog/rtcap_tick_div.sv ***
// Divider that gives a one-cycle enable pulse every DIV clock cycles.
// Assumes a synchronous active-low reset.
module rtcap_tick_div #(
  parameter int DIV = 3814
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (cnt_ff == W'(DIV - 1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  assign tick = (cnt_ff == W'(DIV - 1));

endmodule

// *** verilog/rtcap_alert.sv ***
// Alert flags, power monitor and alert pin driver with AXI4-Lite access.
// Assumes event inputs are synchronous to aclk and one cycle wide.
//
// Implementation choice: the AXI4-Lite register port.
module rtcap_alert
  import rtcap_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int TICK_CYCLES  = TICK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        watchdog_timeout,
  input  wire logic        alarm_match,
  input  wire logic        vcc_below_switch,
  input  wire logic        backup_low_level,
  input  wire logic        osc_stop_detect,
  output logic             store_start,
  output logic             osc_on_backup,
  output logic             host_access_block,
  output logic             alert_o,
  output logic             alert_oe
);
  localparam int PW = $clog2(PULSE_CYCLES + 1);

  rtcap_flags_t flags_ff;
  rtcap_ctrl_t  ctrl_ff;
  rtcap_pin_t   pin_sel;
  logic         backup_ff;
  logic [PW-1:0] pulse_cnt_ff;
  logic [15:0]  tick_cnt_ff;
  logic         tick;
  logic         aw_hold_ff;
  logic         w_hold_ff;
  logic [2:0]   aw_idx_ff;
  logic [31:0]  wdata_ff;
  logic [3:0]   wstrb_ff;
  logic         wr_go;
  logic         rd_go;
  logic         flags_rd;
  logic         wr_flags;
  logic         wr_ctrl;
  logic         wr_ok;
  logic         rd_ok;
  logic [2:0]   ar_idx;
  logic         enabled_any;
  logic         enabled_q_ff;
  logic         alert_new;
  logic         alert_act;
  logic         sq_wave;
  logic         cal_tone;
  logic         wave;
  logic         nxt_o;
  logic         nxt_oe;

  // Register bus: address and data are taken in either order.
  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go   = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign ar_idx  = s_axi_araddr[4:2];
  // Host access is refused while running from backup power.
  assign wr_ok   = !backup_ff &&
                   (aw_idx_ff == IDX_FLAGS || aw_idx_ff == IDX_CTRL);
  assign rd_ok   = !backup_ff && (ar_idx == IDX_FLAGS ||
                   ar_idx == IDX_CTRL || ar_idx == IDX_STAT);
  assign wr_flags = wr_go && wr_ok && aw_idx_ff == IDX_FLAGS &&
                    wstrb_ff[0];
  assign wr_ctrl  = wr_go && wr_ok && aw_idx_ff == IDX_CTRL &&
                    wstrb_ff[0];
  assign flags_rd = rd_go && rd_ok && ar_idx == IDX_FLAGS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_idx_ff  <= 3'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      aw_idx_ff  <= s_axi_awaddr[4:2];
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (!rd_ok) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (ar_idx == IDX_FLAGS) begin
        s_axi_rdata <= {24'h00_0000, flags_ff};
      end else if (ar_idx == IDX_CTRL) begin
        s_axi_rdata <= {24'h00_0000, ctrl_ff};
      end else begin
        s_axi_rdata <= {29'h0000_0000, pulse_cnt_ff != '0,
                        alert_act, backup_ff};
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Power monitor.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_ff   <= 1'b0;
      store_start <= 1'b0;
    end else begin
      backup_ff   <= vcc_below_switch;
      store_start <= vcc_below_switch && !backup_ff;
    end
  end

  assign osc_on_backup     = backup_ff;
  assign host_access_block = backup_ff;

  // Event flags: a set in the same cycle as a read clear survives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= FLAGS_RST;
    end else begin
      flags_ff.watchdog_expired_flag <= (flags_ff.watchdog_expired_flag && !flags_rd) ||
                      watchdog_timeout;
      flags_ff.af  <= (flags_ff.af && !flags_rd) || alarm_match;
      flags_ff.pf  <= (flags_ff.pf && !flags_rd) ||
                      (vcc_below_switch && !backup_ff);
      flags_ff.osc_stop_flag <= osc_stop_detect ||
                       (flags_ff.osc_stop_flag &&
                        !(wr_flags && flags_ff.wen && !wdata_ff[4]));
      // Backup supply is watched in every power state.
      flags_ff.backup_supply_fail_flag <= backup_low_level ||
                      (flags_ff.backup_supply_fail_flag &&
                       !(wr_flags && flags_ff.wen && !wdata_ff[3]));
      if (wr_flags) begin
        flags_ff.wen <= wdata_ff[1];
        if (flags_ff.wen) begin
          flags_ff.cal    <= wdata_ff[2];
          flags_ff.rlatch <= wdata_ff[0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata_ff[7:0];
    end
  end

  // Alert generation.
  assign enabled_any = (flags_ff.watchdog_expired_flag && ctrl_ff.watchdog_alert_enable) ||
                       (flags_ff.af && ctrl_ff.alarm_alert_enable) ||
                       (flags_ff.pf && ctrl_ff.powerfail_alert_enable);
  assign alert_new = enabled_any && !enabled_q_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enabled_q_ff <= 1'b0;
    end else begin
      enabled_q_ff <= enabled_any;
    end
  end

  // The pulse is meant as a host reset, so it runs out on its own timer
  // when nobody reads the flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_ff <= '0;
    end else if (flags_rd || backup_ff || !ctrl_ff.pulse_sel) begin
      pulse_cnt_ff <= '0;
    end else if (alert_new) begin
      pulse_cnt_ff <= PW'(PULSE_CYCLES);
    end else if (pulse_cnt_ff != '0) begin
      pulse_cnt_ff <= pulse_cnt_ff - PW'(1);
    end
  end

  assign alert_act = !backup_ff &&
                     (ctrl_ff.pulse_sel ? (pulse_cnt_ff != '0)
                                        : enabled_any);

  // Square-wave and tone source.
  rtcap_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 16'h0000;
    end else if (tick) begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end

  always_comb begin
    case ({ctrl_ff.rate_hi, ctrl_ff.rate_lo})
      2'h0:    sq_wave = tick_cnt_ff[BIT_1HZ];
      2'h1:    sq_wave = tick_cnt_ff[BIT_512HZ];
      2'h2:    sq_wave = tick_cnt_ff[BIT_4096HZ];
      default: sq_wave = tick_cnt_ff[BIT_32768HZ];
    endcase
  end

  assign cal_tone = tick_cnt_ff[BIT_512HZ];

  always_comb begin
    if (backup_ff) begin
      pin_sel = PIN_OFF;
    end else if (flags_ff.cal) begin
      pin_sel = PIN_CAL;
    end else if (ctrl_ff.square_wave_enable) begin
      pin_sel = PIN_SQW;
    end else if (alert_act) begin
      pin_sel = PIN_ALERT;
    end else begin
      pin_sel = PIN_OFF;
    end
  end

  // The level that counts as active: high for alerts, the wave itself
  // for the tones; open-drain can only pull low.
  always_comb begin
    case (pin_sel)
      PIN_CAL:   wave = cal_tone;
      PIN_SQW:   wave = sq_wave;
      PIN_ALERT: wave = 1'b1;
      default:   wave = 1'b0;
    endcase
    if (pin_sel == PIN_OFF) begin
      nxt_o  = 1'b0;
      nxt_oe = 1'b0;
    end else if (ctrl_ff.act_high) begin
      nxt_o  = wave;
      nxt_oe = 1'b1;
    end else if (pin_sel == PIN_ALERT) begin
      nxt_o  = 1'b0;
      nxt_oe = 1'b1;
    end else begin
      nxt_o  = 1'b0;
      nxt_oe = !wave;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      alert_o  <= nxt_o;
      alert_oe <= nxt_oe;
    end
  end

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_timeout |=> flags_ff.watchdog_expired_flag)
    else $error("watchdog event lost");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_rd && !alarm_match |=> !flags_ff.af)
    else $error("alarm flag not cleared by read");
  a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_ff.pulse_sel && alert_new && !flags_rd && !backup_ff &&
    !$changed(ctrl_ff) |=> pulse_cnt_ff == PW'(PULSE_CYCLES))
    else $error("pulse not loaded with full width");
  a_pulse_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_rd |=> pulse_cnt_ff == '0 ##2 !alert_oe || ctrl_ff.square_wave_enable ||
    flags_ff.cal || !ctrl_ff.pulse_sel)
    else $error("pulse not ended by flags read");
  a_no_backup: assert property (@(posedge aclk) disable iff (!aresetn)
    backup_ff |=> !alert_oe)
    else $error("pin driven on backup power");
  a_store_once: assert property (@(posedge aclk) disable iff (!aresetn)
    store_start |=> !store_start && osc_on_backup)
    else $error("store start not a single pulse");
  a_bus_block: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && backup_ff |=> s_axi_rresp == RESP_SLVERR)
    else $error("read accepted on backup power");
  a_bpf_set: assert property (@(posedge aclk) disable iff (!aresetn)
    backup_low_level |=> flags_ff.backup_supply_fail_flag)
    else $error("backup fail not flagged");
  a_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff.pulse_sel && enabled_any && !backup_ff && !flags_rd &&
    !wr_ctrl && !vcc_below_switch |=> alert_act)
    else $error("level alert dropped without read");
  a_cal_first: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_ff.cal && !backup_ff |-> pin_sel == PIN_CAL)
    else $error("calibration tone not on top");
  a_gate_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff.watchdog_alert_enable && !ctrl_ff.alarm_alert_enable && !ctrl_ff.powerfail_alert_enable |-> !enabled_any)
    else $error("alert without enable");
  c_level_alert: cover property (@(posedge aclk) disable iff (!aresetn)
    alert_new && !ctrl_ff.pulse_sel ##[1:20] flags_rd);
  c_pulse_abort: cover property (@(posedge aclk) disable iff (!aresetn)
    pulse_cnt_ff != '0 && flags_rd);
  c_sqw_on: cover property (@(posedge aclk) disable iff (!aresetn)
    pin_sel == PIN_SQW && alert_act);
  c_power_fail: cover property (@(posedge aclk) disable iff (!aresetn)
    store_start);

endmodule

// *** test/rtcap_host_pin.sv ***
// Host side of the alert pin: resolves the wire level from the driver.
// Assumes the bench says whether the board fits a pull-up on the wire.
module rtcap_host_pin (
  input  wire logic alert_o,
  input  wire logic alert_oe,
  input  wire logic pull_up,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_ff = 1'h0;
  // A released wire with no pull-up shows the inverse of its last level,
  // so a stale value can never pass for a real drive.
  always @(alert_o or alert_oe) begin
    if (alert_oe) begin
      last_ff = alert_o;
    end
  end
  assign pin = alert_oe ? alert_o : (pull_up ? 1'h1 : ~last_ff);
endmodule

// *** test/testbench.sv ***
// Self-checking bench of the alert pin block over AXI4-Lite.
// Assumes the package and the host pin model are compiled first.
module testbench
  import rtcap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PCYC = 20;
  localparam int TCYC = 2;
  localparam int LIMIT = 20000;
  localparam logic [4:0] A_FLAGS = {IDX_FLAGS, 2'h0};
  localparam logic [4:0] A_CTRL  = {IDX_CTRL, 2'h0};
  typedef struct packed {
    logic [7:0] ctrl;
    logic       ev;
    logic [7:0] flags;
    logic       act;
  } rtcap_row_t;
  rtcap_row_t  rows [6] = '{'{8'h88, 1'h0, 8'h80, 1'h1},
    '{8'h08, 1'h0, 8'h80, 1'h0}, '{8'h48, 1'h1, 8'h40, 1'h1},
    '{8'h08, 1'h1, 8'h40, 1'h0}, '{8'hC0, 1'h1, 8'h40, 1'h1},
    '{8'h20, 1'h0, 8'h80, 1'h0}};
  int          bits [4] = '{BIT_1HZ, BIT_512HZ, BIT_4096HZ, BIT_32768HZ};
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        watchdog_timeout = 1'h0, alarm_match = 1'h0;
  logic        vcc_below_switch = 1'h0, backup_low_level = 1'h0;
  logic        osc_stop_detect = 1'h0, pull_up = 1'h0, hi = 1'h1;
  logic        store_start, osc_on_backup, host_access_block;
  logic        alert_o, alert_oe, pin;
  int          fails = 0, comparisons = 0, cycles = 0, n;

  rtcap_alert #(.PULSE_CYCLES(PCYC), .TICK_CYCLES(TCYC)) dut (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .watchdog_timeout, .alarm_match, .vcc_below_switch, .backup_low_level,
    .osc_stop_detect, .store_start, .osc_on_backup, .host_access_block,
    .alert_o, .alert_oe);
  rtcap_host_pin host (.alert_o, .alert_oe, .pull_up, .pin);

  always #2 aclk = ~aclk;

  task automatic summarize();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      $display("unexpected %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || s_axi_awready;
      tw = tw || s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  // The hit input raises an alarm event in the cycle the read is taken.
  task automatic rd(input logic [4:0] a, input logic hit);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    alarm_match <= hit;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    alarm_match <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  task automatic setc(input logic [7:0] v);
    wr(A_CTRL, v);
    hi = v[3];
    pull_up = ~v[3];
  endtask

  task automatic fire(input logic alarm);
    @(posedge aclk);
    watchdog_timeout <= ~alarm;
    alarm_match <= alarm;
    @(posedge aclk);
    watchdog_timeout <= 1'h0;
    alarm_match <= 1'h0;
  endtask

  function automatic logic act(input logic h);
    return h ? pin : ~pin;
  endfunction

  // Gives the cycles between two toggles of the pin, 400 at the most.
  task automatic half(output int c);
    logic s;
    c = 0;
    @(negedge aclk);
    s = alert_o;
    while (alert_o === s && c < 400) begin
      @(negedge aclk);
      c++;
    end
    s = alert_o;
    c = 0;
    while (alert_o === s && c < 400) begin
      @(negedge aclk);
      c++;
    end
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    rd(A_FLAGS, 1'h0);
    check(d, 32'h0, "flags at reset");
    rd(A_CTRL, 1'h0);
    check(d, {24'h0, CTRL_RST}, "control at reset");
    rd(5'h04, 1'h0);
    check(r, RESP_SLVERR, "unmapped read");
    wr(5'h08, 8'hFF);
    check(r, RESP_SLVERR, "unmapped write");
    $display("test reset done");
    foreach (rows[i]) begin
      setc(rows[i].ctrl);
      fire(rows[i].ev);
      repeat (8) @(negedge aclk);
      check(act(hi), rows[i].act, "alert level");
      rd(A_FLAGS, 1'h0);
      check(d, rows[i].flags, "flags");
      repeat (3) @(negedge aclk);
      check(act(hi), 1'h0, "alert after read");
      if (!hi) check(alert_oe, 1'h0, "released");
      rd(A_FLAGS, 1'h0);
      check(d, 32'h0, "flags reread");
    end
    $display("test rows done");
    setc(8'h8C);
    fire(1'h0);
    n = 0;
    repeat (3 * PCYC) begin
      @(negedge aclk);
      if (alert_oe === 1'h1 && act(1'h1) === 1'h1) n++;
    end
    check(n, PCYC, "pulse width");
    rd(A_FLAGS, 1'h0);
    check(d, 32'h80, "flag after pulse");
    fire(1'h0);
    repeat (5) @(posedge aclk);
    rd(A_FLAGS, 1'h0);
    repeat (2) @(negedge aclk);
    check(act(1'h1), 1'h0, "pulse cut");
    setc(8'h08);
    rd(A_FLAGS, 1'h1);
    rd(A_FLAGS, 1'h0);
    check(d, 32'h40, "set beats clear");
    $display("test pulse done");
    setc(8'h28);
    @(posedge aclk);
    vcc_below_switch <= 1'h1;
    n = 0;
    repeat (6) begin
      @(negedge aclk);
      if (store_start === 1'h1) n++;
    end
    check(n, 1, "one store");
    check(osc_on_backup, 1'h1, "osc on backup");
    check(host_access_block, 1'h1, "access blocked");
    check(act(1'h1), 1'h0, "no alert on backup");
    @(posedge aclk);
    backup_low_level <= 1'h1;
    @(posedge aclk);
    backup_low_level <= 1'h0;
    rd(A_FLAGS, 1'h0);
    check({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "read on backup");
    @(posedge aclk);
    vcc_below_switch <= 1'h0;
    repeat (4) @(negedge aclk);
    check(act(1'h1), 1'h1, "power fail alert");
    rd(A_FLAGS, 1'h0);
    check(d, 32'h28, "power flags");
    $display("test power done");
    setc(8'h88);
    fire(1'h0);
    for (int k = 3; k >= 1; k--) begin
      setc(8'h98 | 8'(k));
      half(n);
      check(n, TCYC << bits[k], "wave half period");
    end
    setc(8'h98);
    half(n);
    check(n, 400, "slow wave");
    setc(8'h9B);
    wr(A_FLAGS, 8'h02);
    wr(A_FLAGS, 8'h06);
    half(n);
    check(n, TCYC << BIT_512HZ, "test tone");
    wr(A_FLAGS, 8'h02);
    wr(A_FLAGS, 8'h00);
    $display("test wave done");
    summarize();
  end
endmodule
